// >>> ovl_limiter.sv
// Behaviour
// R01 - protection runs only while submode bit 0 selects closed loop
// R02 - maximum motor current is read in milliamperes
// R03 - peak setting is tenths of percent of rated; peak mA derived
// R04 - allowed peak duration is read in milliseconds
// R05 - energy limit computed from rated, peak and peak duration
// R06 - threshold in A2ms is readable
// R07 - accumulated value kept, compared to threshold, readable in A2ms
// R08 - applied current limit readable in milliamperes
// R09 - enabled only if peak exceeds rated and duration nonzero
// R10 - when not enabled, stay inactive and leave current unlimited
// R11 - peak allowed until limit reached, then immediately rated current
// R12 - applied peak never exceeds maximum motor current
// R13 - status reads zero when inactive, one when active
// R14 - each sample period add squared current excess over squared rated
`timescale 1ns/1ps
module ovl_limiter
    import ovl_pkg::*;
#(
    parameter int unsigned SAMPLE_CYC = ovl_pkg::SAMPLE_CYCLES
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // configuration from software
    input  wire ovl_pkg::ovl_cfg_s      cfg,
    // measured motor current magnitude, mA
    input  wire logic [ovl_pkg::CUR_W-1:0] meas_ma,
    // reported state
    output ovl_pkg::ovl_rpt_s           rpt
);
    import ovl_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    ovl_reg_s s_ff;
    ovl_reg_s nxt_s;

    logic [31:0]      peak_raw;
    logic [CUR_W-1:0] peak_clip;
    logic [CUR_W-1:0] rated_clip;
    logic             en;
    logic             tick_hit;
    logic [31:0]      meas_sq;
    logic [31:0]      rated_sq;
    logic [31:0]      peak_sq;
    logic [ACC_W-1:0] acc_sum;

    // ----------------------------------------
    // derived settings
    // ----------------------------------------
    always_comb begin
        // permille of rated gives peak in mA
        peak_raw = (32'(cfg.rated_ma) * 32'(cfg.peak_permille)) / 32'(PERMILLE_FULL); // [R02] [R03]
        peak_clip = (peak_raw > 32'(cfg.max_motor_ma)) ? cfg.max_motor_ma
                                                       : peak_raw[CUR_W-1:0]; // [R12]
        rated_clip = (cfg.rated_ma > cfg.max_motor_ma) ? cfg.max_motor_ma : cfg.rated_ma; // [R12]
        en = cfg.submode[SUBMODE_CL_BIT]                     // [R01]
             && (peak_raw > 32'(cfg.rated_ma))
             && (cfg.peak_ms != '0);                         // [R09]
        tick_hit = (s_ff.tick == TCK_W'(SAMPLE_CYC - 1));
        meas_sq  = 32'(meas_ma) * 32'(meas_ma);
        rated_sq = 32'(cfg.rated_ma) * 32'(cfg.rated_ma);
        peak_sq  = 32'(peak_clip) * 32'(peak_clip);
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        nxt_s = s_ff;
        nxt_s.tick = tick_hit ? RST_TICK : s_ff.tick + TCK_W'(1);
        // limit in mA2*ms, duration in ms
        nxt_s.lim = (peak_sq > rated_sq)
                  ? 48'(peak_sq - rated_sq) * 48'(cfg.peak_ms) : RST_ACC; // [R04] [R05]
        acc_sum = s_ff.acc;
        // one sample = one ms; cooling below rated drains, floored at zero
        if (tick_hit) begin
            if (meas_sq >= rated_sq) begin
                acc_sum = s_ff.acc + 48'(meas_sq - rated_sq); // [R14]
            end else if (s_ff.acc > 48'(rated_sq - meas_sq)) begin
                acc_sum = s_ff.acc - 48'(rated_sq - meas_sq);
            end else begin
                acc_sum = RST_ACC;
            end
        end
        // saturate at the limit so the sum cannot wrap
        if (acc_sum > nxt_s.lim) begin
            acc_sum = nxt_s.lim;
        end
        nxt_s.acc = acc_sum;                                  // [R07]
        case (s_ff.st)
            OVL_OFF: begin
                nxt_s.acc = RST_ACC;
                if (en) begin
                    nxt_s.st = OVL_PEAK;
                end
            end
            OVL_PEAK: begin
                if (acc_sum >= nxt_s.lim) begin
                    nxt_s.st = OVL_RATED;                     // [R11]
                end
            end
            OVL_RATED: begin
                // release only once fully cooled, gives hysteresis
                if (acc_sum == RST_ACC) begin
                    nxt_s.st = OVL_PEAK;
                end
            end
            default: begin
                nxt_s.st = OVL_OFF;
            end
        endcase
        if (!en) begin
            nxt_s.st  = OVL_OFF;                              // [R10]
            nxt_s.acc = RST_ACC;
        end
        case (nxt_s.st)
            OVL_PEAK:  nxt_s.rpt.applied_current_limit = peak_clip;   // [R08] [R12]
            OVL_RATED: nxt_s.rpt.applied_current_limit = rated_clip;  // [R11]
            default:   nxt_s.rpt.applied_current_limit = NO_LIMIT_MA; // [R10]
        endcase
        nxt_s.rpt.status    = (nxt_s.st != OVL_OFF);                  // [R13]
        nxt_s.rpt.threshold = RPT_W'(nxt_s.lim / 48'(MA2_PER_A2));    // [R06]
        nxt_s.rpt.accumulated_energy_value = RPT_W'(nxt_s.acc / 48'(MA2_PER_A2)); // [R07]
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_ff.st   <= OVL_OFF;
            s_ff.tick <= RST_TICK;
            s_ff.acc  <= RST_ACC;
            s_ff.lim  <= RST_ACC;
            s_ff.rpt  <= '{threshold: '0, accumulated_energy_value: '0,
                           applied_current_limit: NO_LIMIT_MA, status: 1'b0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign rpt = s_ff.rpt;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_peak;
        s_ff.st == OVL_PEAK;
    endsequence

    sequence s_rated;
        s_ff.st == OVL_RATED;
    endsequence

    sequence s_off;
        s_ff.st == OVL_OFF;
    endsequence

    property p_open_loop_off;
        !cfg.submode[SUBMODE_CL_BIT] |=> !rpt.status;
    endproperty
    a_open_loop_off: assert property (p_open_loop_off) else $error("active in open loop"); // [R01]

    property p_no_duration;
        cfg.peak_ms == '0 |=> !rpt.status && rpt.applied_current_limit == NO_LIMIT_MA;
    endproperty
    a_no_duration: assert property (p_no_duration) else $error("limit applied without duration"); // [R10]

    property p_enable;
        cfg.submode[SUBMODE_CL_BIT] && cfg.peak_ms != '0 && cfg.rated_ma != '0
            && cfg.peak_permille >= 16'h07d0 |=> rpt.status;
    endproperty
    a_enable: assert property (p_enable) else $error("not enabled with valid settings"); // [R09]

    property p_max_clamp;
        rpt.status |-> rpt.applied_current_limit <= $past(cfg.max_motor_ma);
    endproperty
    a_max_clamp: assert property (p_max_clamp) else $error("limit above max motor current"); // [R12]

    property p_trip;
        s_peak ##1 s_rated |-> s_ff.acc >= s_ff.lim
            && rpt.applied_current_limit <= $past(cfg.rated_ma);
    endproperty
    a_trip: assert property (p_trip) else $error("trip without reaching limit"); // [R11]

    property p_no_early_trip;
        s_peak ##1 s_peak |-> s_ff.acc < s_ff.lim;
    endproperty
    a_no_early_trip: assert property (p_no_early_trip) else $error("limit reached but peak kept"); // [R11]

    property p_sample_only;
        s_ff.st != OVL_OFF && !tick_hit && en && $stable(cfg) |=> $stable(s_ff.acc);
    endproperty
    a_sample_only: assert property (p_sample_only) else $error("accumulator moved off sample"); // [R14]

    property p_status_tie;
        !$past(rst) |-> rpt.status == $past(en);
    endproperty
    a_status_tie: assert property (p_status_tie) else $error("status disagrees with enable"); // [R13]

    // ----------------------------------------
    // checks: reset and enable
    // ----------------------------------------
    property p_reset_clear;
        $past(rst) |-> !rpt.status && rpt.applied_current_limit == NO_LIMIT_MA
            && rpt.threshold == '0 && rpt.accumulated_energy_value == '0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared by reset"); // [R10]

    property p_off_unlimited;
        !$past(en) |-> !rpt.status && rpt.applied_current_limit == NO_LIMIT_MA
            && rpt.accumulated_energy_value == '0;
    endproperty
    a_off_unlimited: assert property (p_off_unlimited) else $error("limit applied while disabled"); // [R10]

    property p_disable;
        !en |=> s_ff.st == OVL_OFF && s_ff.acc == RST_ACC;
    endproperty
    a_disable: assert property (p_disable) else $error("protection kept while disabled"); // [R10]

    property p_status_steady;
        !$past(rst) && $stable(cfg) |=> $stable(rpt.status);
    endproperty
    a_status_steady: assert property (p_status_steady) else $error("status moved with settings held"); // [R13]

    property p_acc_zero_off;
        s_off |-> s_ff.acc == RST_ACC;
    endproperty
    a_acc_zero_off: assert property (p_acc_zero_off) else $error("accumulator kept while off"); // [R10]

    property p_enter_peak;
        s_off ##1 s_peak |-> s_ff.acc == RST_ACC && rpt.accumulated_energy_value == '0;
    endproperty
    a_enter_peak: assert property (p_enter_peak) else $error("enable did not start from zero"); // [R07]

    property p_threshold_hold;
        !$past(rst) && $stable(cfg) |=> $stable(rpt.threshold);
    endproperty
    a_threshold_hold: assert property (p_threshold_hold) else $error("threshold moved with settings held"); // [R06]

    // ----------------------------------------
    // checks: accumulation
    // ----------------------------------------
    // direction only; exact step sizes are left to the bench
    property p_tick_wrap;
        tick_hit |=> s_ff.tick == RST_TICK;
    endproperty
    a_tick_wrap: assert property (p_tick_wrap) else $error("sample counter did not wrap"); // [R14]

    property p_tick_step;
        !tick_hit |=> s_ff.tick == TCK_W'($past(s_ff.tick) + TCK_W'(1));
    endproperty
    a_tick_step: assert property (p_tick_step) else $error("sample counter skipped"); // [R14]

    property p_heat;
        s_ff.st != OVL_OFF && tick_hit && en && $stable(cfg) && meas_ma >= cfg.rated_ma
            |=> s_ff.acc >= $past(s_ff.acc);
    endproperty
    a_heat: assert property (p_heat) else $error("accumulator fell above rated current"); // [R14]

    property p_cool;
        s_ff.st != OVL_OFF && tick_hit && en && meas_ma < cfg.rated_ma
            |=> s_ff.acc <= $past(s_ff.acc);
    endproperty
    a_cool: assert property (p_cool) else $error("accumulator rose below rated current"); // [R14]

    property p_acc_bound;
        s_ff.acc <= s_ff.lim && rpt.accumulated_energy_value <= rpt.threshold;
    endproperty
    a_acc_bound: assert property (p_acc_bound) else $error("accumulator above threshold"); // [R07]

    property p_peak_dwell;
        s_ff.st == OVL_PEAK && !tick_hit && en && $stable(cfg) && s_ff.acc < s_ff.lim
            |=> s_peak;
    endproperty
    a_peak_dwell: assert property (p_peak_dwell) else $error("peak left off sample"); // [R11]

    property p_rated_dwell;
        s_ff.st == OVL_RATED && !tick_hit && en && $stable(cfg) && s_ff.acc != RST_ACC
            |=> s_rated;
    endproperty
    a_rated_dwell: assert property (p_rated_dwell) else $error("rated limit released off sample"); // [R11]

    // ----------------------------------------
    // checks: applied limit
    // ----------------------------------------
    property p_rated_applied;
        s_rated |-> rpt.applied_current_limit == (($past(cfg.rated_ma) > $past(cfg.max_motor_ma))
                                                  ? $past(cfg.max_motor_ma) : $past(cfg.rated_ma));
    endproperty
    a_rated_applied: assert property (p_rated_applied) else $error("wrong limit while tripped"); // [R11]

    property p_peak_above;
        s_ff.st == OVL_PEAK && $past(cfg.max_motor_ma) > $past(cfg.rated_ma)
            |-> rpt.applied_current_limit > $past(cfg.rated_ma);
    endproperty
    a_peak_above: assert property (p_peak_above) else $error("peak limit not above rated"); // [R03]

    property p_release;
        s_rated ##1 s_peak |-> s_ff.acc == RST_ACC;
    endproperty
    a_release: assert property (p_release) else $error("released before cooling"); // [R11]

endmodule // ovl_limiter

// >>> ovl_pkg.sv
package ovl_pkg;

    // ----------------------------------------
    // widths and scaling
    // ----------------------------------------
    localparam int CUR_W = 16;
    localparam int ACC_W = 48;
    localparam int RPT_W = 32;
    localparam int TCK_W = 16;
    localparam int unsigned PERMILLE_FULL = 1000;
    localparam int unsigned MA2_PER_A2    = 1000000;
    localparam int SUBMODE_CL_BIT = 0;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_PS    = 25000;
    localparam int unsigned SAMPLE_PERIOD_US = 1000;
    localparam int unsigned SAMPLE_CYCLES    = (SAMPLE_PERIOD_US * 1000 * 1000) / CLK_PERIOD_PS;

    // ----------------------------------------
    // reset and idle values
    // ----------------------------------------
    localparam logic [CUR_W-1:0] NO_LIMIT_MA = 16'hffff;
    localparam logic [ACC_W-1:0] RST_ACC     = 48'h0;
    localparam logic [TCK_W-1:0] RST_TICK    = 16'h0;

    typedef enum logic [1:0] {
        OVL_OFF   = 2'b00,
        OVL_PEAK  = 2'b01,
        OVL_RATED = 2'b10
    } ovl_state_e;

    typedef struct packed {
        logic [CUR_W-1:0] submode;
        logic [CUR_W-1:0] max_motor_ma;
        logic [CUR_W-1:0] rated_ma;
        logic [CUR_W-1:0] peak_permille;
        logic [CUR_W-1:0] peak_ms;
    } ovl_cfg_s;

    typedef struct packed {
        logic [RPT_W-1:0] threshold;
        logic [RPT_W-1:0] accumulated_energy_value;
        logic [CUR_W-1:0] applied_current_limit;
        logic             status;
    } ovl_rpt_s;

    typedef struct packed {
        ovl_state_e       st;
        logic [TCK_W-1:0] tick;
        logic [ACC_W-1:0] acc;
        logic [ACC_W-1:0] lim;
        ovl_rpt_s         rpt;
    } ovl_reg_s;

endpackage

// >>> ovl_motor_stage.sv
`timescale 1ns/1ps
module ovl_motor_stage
    import ovl_pkg::*;
(
    // demand and limit
    input  wire logic [ovl_pkg::CUR_W-1:0] demand_ma,
    input  wire logic [ovl_pkg::CUR_W-1:0] limit_ma,
    // current reaching the motor
    output logic      [ovl_pkg::CUR_W-1:0] meas_ma
);
    // obeys the limit at once; a slower loop would only shift samples
    assign meas_ma = (demand_ma > limit_ma) ? limit_ma : demand_ma;
endmodule // ovl_motor_stage

// >>> motor_i2t_overload_limiter_bench.sv
`timescale 1ns/1ps
module motor_i2t_overload_limiter_bench;
    import ovl_pkg::*;
    localparam int SC = 4;
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    ovl_cfg_s         cfg = '0;
    logic [CUR_W-1:0] demand = '0;
    logic [CUR_W-1:0] meas;
    ovl_rpt_s         rpt;
    int               failures = 0;
    int               n_compared = 0;
    int               seed = 41;
    int               r;
    int               p;
    ovl_limiter #(.SAMPLE_CYC(SC)) dut (.clk(clk), .rst(rst), .cfg(cfg), .meas_ma(meas), .rpt(rpt));
    ovl_motor_stage stage (.demand_ma(demand), .limit_ma(rpt.applied_current_limit), .meas_ma(meas));
    initial forever #12.5 clk = ~clk;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // model: integer reference of one configuration run
    task automatic run_case(input int sub, input int mx, input int rt, input int perm, input int ms);
        longint pk;
        longint pc;
        longint rc;
        longint lim;
        int     on;
        int     nd;
        int     exp_lim[$];
        pk = (longint'(rt) * perm) / 1000;
        pc = (pk > mx) ? mx : pk;
        rc = (rt > mx) ? mx : rt;
        exp_lim = '{int'(pc), int'(rc), int'(rc), int'(pc)};
        on = ((sub & 1) == 1 && pk > rt && ms != 0) ? 1 : 0;
        lim = (pc * pc - longint'(rt) * rt) * ms;
        cfg = '{16'(sub), 16'(mx), 16'(rt), 16'(perm), 16'(ms)};
        demand = '0;
        wait_cyc(3);
        check(32'(rpt.status), 32'(on));
        check(32'(rpt.applied_current_limit), on ? 32'(pc) : 32'h0000ffff);
        if (on == 1) begin
            check(rpt.threshold, 32'(lim / MA2_PER_A2));
            demand = 16'hfff0;
            wait_cyc(SC * (ms - 1) - 2);
            check(32'(rpt.applied_current_limit), 32'(exp_lim.pop_front()));
            wait_cyc(SC * 3 + 3);
            check(32'(rpt.applied_current_limit), 32'(exp_lim.pop_front()));
            check(rpt.accumulated_energy_value, 32'(lim / MA2_PER_A2));
            demand = '0;
            nd = int'((lim + rc * rc - 1) / (rc * rc));
            wait_cyc(SC * (nd - 1) - 2);
            check(32'(rpt.applied_current_limit), 32'(exp_lim.pop_front()));
            wait_cyc(SC * 3 + 3);
            check(32'(rpt.applied_current_limit), 32'(exp_lim.pop_front()));
        end
        check(rpt.accumulated_energy_value, on ? 32'h0 : 32'h0);
        $display("case sub=%0d rated=%0d peak=%0d ms=%0d done", sub, rt, perm, ms);
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        wait_cyc(2);
        rst = 1'b0;
        wait_cyc(1);
        check(32'(rpt.status), 32'h0);
        check(32'(rpt.applied_current_limit), 32'h0000ffff);
        run_case(1, 1500, 1000, 2000, 10);
        run_case(0, 1500, 1000, 2000, 10);
        run_case(1, 1500, 1000, 1000, 10);
        run_case(1, 1500, 1000, 2000, 0);
        run_case(3, 5000, 1000, 1500, 1);
        // mid-run reset with a valid setting held
        rst = 1'b1;
        wait_cyc(2);
        check(32'(rpt.status), 32'h0);
        check(32'(rpt.applied_current_limit), 32'h0000ffff);
        check(rpt.threshold, 32'h0);
        check(rpt.accumulated_energy_value, 32'h0);
        rst = 1'b0;
        wait_cyc(1);
        check(32'(rpt.status), 32'h1);
        check(rpt.threshold, 32'h1);
        $display("mid-run reset done");
        for (int i = 0; i < 6; i++) begin
            r = 200 + int'($unsigned($random(seed)) % 1000);
            p = 1001 + int'($unsigned($random(seed)) % 2000);
            run_case(1, r + 1 + int'($unsigned($random(seed)) % 2000), r, p,
                     1 + int'($unsigned($random(seed)) % 20));
        end
        finish_test();
    end
    // longest case is under a thousand cycles; forty thousand cycles, forty times that, is ample
    initial begin
        #(40000 * 25);
        failures++;
        finish_test();
    end
endmodule // motor_i2t_overload_limiter_bench
